// File: logic/tpwm_defs.svh
// register offsets, field positions and reset values of the timer pwm block
// assumes the includer already imports tpwm_pkg where types are needed
`ifndef TPWM_DEFS_SVH
`define TPWM_DEFS_SVH

// register offsets on the 8-bit register port
`define TPWM_A_CTRL   8'h88
`define TPWM_A_MODE   8'h89
`define TPWM_A_TL0    8'h8A
`define TPWM_A_TL1    8'h8B
`define TPWM_A_TH0    8'h8C
`define TPWM_A_TH1    8'h8D
`define TPWM_A_CTRLB  8'h91
`define TPWM_A_RL0    8'h92
`define TPWM_A_RH0    8'h93
`define TPWM_A_RL1    8'h94
`define TPWM_A_RH1    8'h95
`define TPWM_A_TPS    8'h96

// timer_control_b fields
`define TPWM_CTRLB_RST 8'h24
`define TPWM_B_EN1     7
`define TPWM_B_EN0     6
`define TPWM_B_TIMER1_LOG_PRESCALE    3
`define TPWM_B_TIMER0_LOG_PRESCALE    0

// timer_mode_register fields, per timer at base 4*i
`define TPWM_M_STRIDE  4
`define TPWM_M_MODE    0
`define TPWM_M_CT      2
`define TPWM_M_GATE    3

// timer control register fields
`define TPWM_C_TR0     4
`define TPWM_C_TF0     5
`define TPWM_C_TR1     6
`define TPWM_C_TF1     7

// counter constants
`define TPWM_FF        8'hFF
`define TPWM_ZERO      8'h00
`define TPWM_LOG_TOP   3'h7

`endif

// File: logic/tpwm_pkg.sv
// types shared by the timer pwm block
// assumes an 8-bit register port and two timers
package tpwm_pkg;

  // mode field encodings 00..11 in order
  typedef enum logic [1:0] {
    TPWM_MODE0,
    TPWM_MODE1,
    TPWM_MODE2,
    TPWM_MODE3
  } tpwm_mode_t;

  // register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } tpwm_bus_t;

  // one timer pin: output value and active-low output enable
  typedef struct packed {
    logic out;
    logic oe_n;
  } tpwm_pin_t;

  // whole state of the block
  typedef struct packed {
    logic [7:0]      ctrlb;
    logic [7:0]      timer_mode_register;
    logic [1:0]      run;
    logic [1:0]      tf;
    logic [3:0]      common_timer_prescale;
    logic [3:0]      div;
    logic [1:0][7:0] tl;
    logic [1:0][7:0] th;
    logic [1:0][7:0] rl;
    logic [1:0][7:0] rh;
    logic [1:0][7:0] cmp;
    logic [1:0]      pwm;
    logic [1:0]      pin_prev;
    logic            baud;
    logic [7:0]      rdata;
  } tpwm_state_t;

endpackage

// File: logic/tpwm_timers.sv
// two 8/16-bit timers with pwm output modes and their control registers
// assumes pins and gate inputs are synchronous to clock, register port reads
// answer one cycle after the read strobe
//
// Operation
// R1 - bit 7 enables timer 1 pwm, bit 6 enables timer 0 pwm, independently
// R2 - mode 0 prescaler uses field plus one low-byte bits, resets to five
// R3 - in pwm the waveform drives the timer pin instead of sampling it
// R4 - software selects timer operation and an output pin mode for pwm
// R5 - overflow flags and timer 1 baud tick keep working in pwm
// R6 - gate input still halts counting and waveform in pwm; split high byte ignores it
// R7 - output high at count 00, low when count reaches compare value
// R8 - duty reload takes effect only at the high byte FF to 00 wrap
// R9 - duty value 00 keeps output continuously low
// R10 - pwm mode 0 uses low byte as logarithmic prescaler set by field
// R11 - modes 0 and 1 load compare and set high on overflow, clear on match
// R12 - pwm mode 1 low byte is linear prescaler reloading from low reload
// R13 - pwm mode 2 is 8-bit auto-reload toggling pin each low overflow
// R14 - pwm mode 2 leaves both reload bytes free as storage
// R15 - timer 1 in mode 3 freezes like a cleared run bit
// R16 - timer 0 mode 3 splits into two 8-bit pwm counters
// R17 - split low channel uses timer 0 controls, high uses timer 1 controls
// R18 - split low reload sets low duty, high reload sets high duty
// R19 - timer 1 stops in its mode 3, resumes outside, keeps baud tick
// R20 - each pwm channel has four modes from its mode register bits
// R21 - mode field encodes modes 0 to 3 as 00 to 11
// R22 - clearing pwm enable releases the pin back to input use
//
// Local design decision: strobed register access.
module tpwm_timers (
  // clock and reset
  input  wire logic                 clock,
  input  wire logic                 nrst,
  // register port
  input  wire tpwm_pkg::tpwm_bus_t  bus,
  output logic [7:0]                rdata,
  // timer pins
  input  wire logic [1:0]           pin_in,
  output tpwm_pkg::tpwm_pin_t [1:0] pin,
  // gate inputs
  input  wire logic [1:0]           gate_in,
  // flags and baud tick
  output logic [1:0]                overflow_flag,
  output logic                      baud_tick
);
  import tpwm_pkg::*;
  `include "tpwm_defs.svh"

  localparam tpwm_state_t RST_ST = '{ctrlb: `TPWM_CTRLB_RST, default: '0};

  tpwm_state_t s_q;
  tpwm_state_t s_d;
  logic [1:0]  rst_sync_q;
  logic        rst_n;

  // next compare and output of one edge-aligned pwm channel, {cmp, out}
  function automatic logic [8:0] pwm_ch(input logic [7:0] cnt, input logic [7:0] cmp,
                                        input logic [7:0] rld, input logic out,
                                        input logic step);
    logic [7:0] nxt;
    nxt = cnt + 8'h01;
    if (!step) begin
      pwm_ch = {cmp, out};
    end else if (cnt == `TPWM_FF) begin
      // R8 reload at wrap
      // R9 zero stays low
      pwm_ch = {rld, rld != `TPWM_ZERO};
    end else if (nxt == cmp) begin
      // R7 low on match
      pwm_ch = {cmp, 1'b0};
    end else begin
      pwm_ch = {cmp, out};
    end
  endfunction

  // register select, shared by read and write paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] reg_a);
    hit = (a == reg_a);
  endfunction

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // next state
  always_comb begin
    logic             tick;
    logic             split;
    logic [1:0]       en;
    logic [1:0]       hw_tf;
    logic [8:0]       ch;
    logic [7:0]       mask;
    logic [2:0]       psc;
    logic             cy;
    logic             pwm_en;
    tpwm_mode_t       md;
    tick   = 1'b0;
    split  = 1'b0;
    en     = 2'h0;
    hw_tf  = 2'h0;
    ch     = 9'h000;
    mask   = 8'h00;
    psc    = 3'h0;
    cy     = 1'b0;
    pwm_en = 1'b0;
    md     = TPWM_MODE0;
    s_d    = s_q;
    s_d.baud = 1'b0;
    s_d.pin_prev = pin_in;

    // common prescaler: one count every tps+1 clocks
    tick = (s_q.div == s_q.common_timer_prescale);
    s_d.div = tick ? 4'h0 : s_q.div + 4'h1;

    split = (tpwm_mode_t'(s_q.timer_mode_register[`TPWM_M_MODE +: 2]) == TPWM_MODE3);

    // count enables, gate and counter/timer selection per timer
    for (int i = 0; i < 2; i++) begin
      // R6 gate halts count
      en[i] = s_q.run[i] & (~s_q.timer_mode_register[i*`TPWM_M_STRIDE + `TPWM_M_GATE] | gate_in[i]);
      // R4 counter input only when not driving
      if (s_q.timer_mode_register[i*`TPWM_M_STRIDE + `TPWM_M_CT] && !s_q.ctrlb[`TPWM_B_EN0 + i]) begin
        en[i] = en[i] & s_q.pin_prev[i] & ~pin_in[i];
      end else begin
        en[i] = en[i] & tick;
      end
    end
    // R19 timer 1 runs on mode alone while timer 0 is split
    if (split) begin
      en[1] = tick;
    end

    // counting, one pass per timer
    for (int i = 0; i < 2; i++) begin
      // R20 mode from mode register
      // R21 two-bit encoding
      md     = tpwm_mode_t'(s_q.timer_mode_register[i*`TPWM_M_STRIDE + `TPWM_M_MODE +: 2]);
      // R1 independent enables
      pwm_en = s_q.ctrlb[`TPWM_B_EN0 + i];
      psc    = (i == 0) ? s_q.ctrlb[`TPWM_B_TIMER0_LOG_PRESCALE +: 3] : s_q.ctrlb[`TPWM_B_TIMER1_LOG_PRESCALE +: 3];
      // split timer 1 is counted below; here it would clobber the high channel and flag one
      if (split && i == 1) begin
        continue;
      end
      case (md)
        TPWM_MODE0: begin
          // R2 active low bits are field plus one
          // R10 logarithmic prescaler
          mask = `TPWM_FF >> (`TPWM_LOG_TOP - psc);
          cy   = en[i] & ((s_q.tl[i] & mask) == mask);
          if (en[i]) begin
            s_d.tl[i] = (s_q.tl[i] + 8'h01) & mask;
          end
          if (cy) begin
            s_d.th[i] = s_q.th[i] + 8'h01;
          end
          hw_tf[i] = cy & (s_q.th[i] == `TPWM_FF);
          // R11 overflow loads compare
          ch = pwm_ch(s_q.th[i], s_q.cmp[i], s_q.rh[i], s_q.pwm[i], cy);
          s_d.cmp[i] = ch[8:1];
          s_d.pwm[i] = ch[0];
        end
        TPWM_MODE1: begin
          if (pwm_en) begin
            // R12 linear prescaler with reload
            cy = en[i] & (s_q.tl[i] == `TPWM_FF);
            if (en[i]) begin
              s_d.tl[i] = cy ? s_q.rl[i] : s_q.tl[i] + 8'h01;
            end
            if (cy) begin
              s_d.th[i] = s_q.th[i] + 8'h01;
            end
            hw_tf[i] = cy & (s_q.th[i] == `TPWM_FF);
            // R11 overflow loads compare
            ch = pwm_ch(s_q.th[i], s_q.cmp[i], s_q.rh[i], s_q.pwm[i], cy);
            s_d.cmp[i] = ch[8:1];
            s_d.pwm[i] = ch[0];
          end else if (en[i]) begin
            // plain 16-bit auto-reload
            hw_tf[i] = ({s_q.th[i], s_q.tl[i]} == {`TPWM_FF, `TPWM_FF});
            {s_d.th[i], s_d.tl[i]} = hw_tf[i] ? {s_q.rh[i], s_q.rl[i]}
                                             : {s_q.th[i], s_q.tl[i]} + 16'h0001;
          end
        end
        TPWM_MODE2: begin
          // R13 auto-reload from high byte, toggle on overflow
          // R14 reload bytes untouched
          cy = en[i] & (s_q.tl[i] == `TPWM_FF);
          if (en[i]) begin
            s_d.tl[i] = cy ? s_q.th[i] : s_q.tl[i] + 8'h01;
          end
          hw_tf[i] = cy;
          if (cy) begin
            s_d.pwm[i] = ~s_q.pwm[i];
          end
        end
        TPWM_MODE3: begin
          if (i == 0) begin
            // R16 two separate 8-bit counters
            // R17 low byte on timer 0 controls
            // R18 low reload feeds low duty
            hw_tf[0] = en[0] & (s_q.tl[0] == `TPWM_FF);
            if (en[0]) begin
              s_d.tl[0] = s_q.tl[0] + 8'h01;
            end
            ch = pwm_ch(s_q.tl[0], s_q.cmp[0], s_q.rl[0], s_q.pwm[0], en[0]);
            s_d.cmp[0] = ch[8:1];
            s_d.pwm[0] = ch[0];
            // R17 high byte on timer 1 run, timer only
            cy = s_q.run[1] & tick;
            if (cy) begin
              s_d.th[0] = s_q.th[0] + 8'h01;
            end
            hw_tf[1] = cy & (s_q.th[0] == `TPWM_FF);
            // R18 high reload feeds high duty
            ch = pwm_ch(s_q.th[0], s_q.cmp[1], s_q.rh[0], s_q.pwm[1], cy);
            s_d.cmp[1] = ch[8:1];
            s_d.pwm[1] = ch[0];
          end
          // R15 timer 1 frozen, nothing to do
        end
        default: begin
          s_d.tl[i] = s_q.tl[i];
        end
      endcase
    end

    // R19 timer 1 overflow still gives the baud tick, flag goes to the split high byte
    if (split && !s_q.ctrlb[`TPWM_B_EN1]) begin
      s_d.pwm[1] = s_q.pwm[1];
    end
    if (split) begin
      // timer 1 keeps counting but may not touch flag one
      s_d.baud = en[1] & (tpwm_mode_t'(s_q.timer_mode_register[`TPWM_M_STRIDE +: 2]) != TPWM_MODE3)
                 & (s_q.tl[1] == `TPWM_FF);
      if (s_d.baud && tpwm_mode_t'(s_q.timer_mode_register[`TPWM_M_STRIDE +: 2]) == TPWM_MODE2) begin
        s_d.tl[1] = s_q.th[1];
      end else if (s_d.baud || (en[1] && tpwm_mode_t'(s_q.timer_mode_register[`TPWM_M_STRIDE +: 2])
                                         != TPWM_MODE3)) begin
        s_d.tl[1] = s_q.tl[1] + 8'h01;
      end
    end else begin
      // R5 baud tick from timer 1 overflow in any mode
      s_d.baud = hw_tf[1];
    end

    // register writes; software wins over the count it overwrites
    if (bus.we) begin
      if (hit(bus.addr, `TPWM_A_CTRLB)) s_d.ctrlb = bus.wdata;
      if (hit(bus.addr, `TPWM_A_MODE))  s_d.timer_mode_register  = bus.wdata;
      if (hit(bus.addr, `TPWM_A_TPS))   s_d.common_timer_prescale   = bus.wdata[3:0];
      if (hit(bus.addr, `TPWM_A_TL0))   s_d.tl[0] = bus.wdata;
      if (hit(bus.addr, `TPWM_A_TL1))   s_d.tl[1] = bus.wdata;
      if (hit(bus.addr, `TPWM_A_TH0))   s_d.th[0] = bus.wdata;
      if (hit(bus.addr, `TPWM_A_TH1))   s_d.th[1] = bus.wdata;
      // R8 reload bytes only reach the compare at the wrap
      if (hit(bus.addr, `TPWM_A_RL0))   s_d.rl[0] = bus.wdata;
      if (hit(bus.addr, `TPWM_A_RH0))   s_d.rh[0] = bus.wdata;
      if (hit(bus.addr, `TPWM_A_RL1))   s_d.rl[1] = bus.wdata;
      if (hit(bus.addr, `TPWM_A_RH1))   s_d.rh[1] = bus.wdata;
      if (hit(bus.addr, `TPWM_A_CTRL)) begin
        s_d.run = {bus.wdata[`TPWM_C_TR1], bus.wdata[`TPWM_C_TR0]};
        s_d.tf  = {bus.wdata[`TPWM_C_TF1], bus.wdata[`TPWM_C_TF0]};
      end
    end
    // R5 flags keep setting in pwm; a set beats a same-cycle clear
    s_d.tf = s_d.tf | hw_tf;

    // read data, valid only in the cycle after the strobe
    s_d.rdata = `TPWM_ZERO;
    if (bus.re) begin
      if (hit(bus.addr, `TPWM_A_CTRLB)) s_d.rdata = s_q.ctrlb;
      if (hit(bus.addr, `TPWM_A_MODE))  s_d.rdata = s_q.timer_mode_register;
      if (hit(bus.addr, `TPWM_A_TPS))   s_d.rdata = {4'h0, s_q.common_timer_prescale};
      if (hit(bus.addr, `TPWM_A_TL0))   s_d.rdata = s_q.tl[0];
      if (hit(bus.addr, `TPWM_A_TL1))   s_d.rdata = s_q.tl[1];
      if (hit(bus.addr, `TPWM_A_TH0))   s_d.rdata = s_q.th[0];
      if (hit(bus.addr, `TPWM_A_TH1))   s_d.rdata = s_q.th[1];
      if (hit(bus.addr, `TPWM_A_RL0))   s_d.rdata = s_q.rl[0];
      if (hit(bus.addr, `TPWM_A_RH0))   s_d.rdata = s_q.rh[0];
      if (hit(bus.addr, `TPWM_A_RL1))   s_d.rdata = s_q.rl[1];
      if (hit(bus.addr, `TPWM_A_RH1))   s_d.rdata = s_q.rh[1];
      if (hit(bus.addr, `TPWM_A_CTRL)) begin
        s_d.rdata = {s_q.tf[1], s_q.run[1], s_q.tf[0], s_q.run[0], 4'h0};
      end
    end
  end

  // state register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= RST_ST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs, all from flops
  assign rdata         = s_q.rdata;
  assign overflow_flag = s_q.tf;
  assign baud_tick     = s_q.baud;

  // pins: the high byte of a split timer 0 drives the timer 1 pin
  for (genvar g = 0; g < 2; g++) begin : g_pin
    // R3 waveform out on the input pin
    assign pin[g].out  = s_q.pwm[g];
    // R22 enable cleared releases the pin
    assign pin[g].oe_n = ~s_q.ctrlb[`TPWM_B_EN0 + g];
  end

endmodule

// File: tb/test_timer_pwm_channels.sv
// self-checking bench for the timer pwm block
// assumes the load model pulls released pins high
`include "tpwm_defs.svh"
module test_timer_pwm_channels;
  timeunit 1ns;
  timeprecision 1ns;
  import tpwm_pkg::*;
  logic            clock;
  logic            nrst;
  tpwm_bus_t       bus;
  logic [7:0]      rdata;
  logic [1:0]      pin_in;
  tpwm_pin_t [1:0] pin;
  logic [1:0]      gate_in;
  logic [1:0]      overflow_flag;
  logic            baud_tick;
  int              mismatches;
  int              checked;
  tpwm_timers i_tpwm_timers (.clock(clock), .nrst(nrst), .bus(bus), .rdata(rdata),
    .pin_in(pin_in), .pin(pin), .gate_in(gate_in), .overflow_flag(overflow_flag),
    .baud_tick(baud_tick));
  tpwm_load i_tpwm_load (.pin(pin), .pin_in(pin_in));
  // 10 MHz clock
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // a gap cycle after each strobe keeps every signal to one assignment per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus.addr <= a;
    bus.wdata <= d;
    bus.we <= 1'b1;
    @(posedge clock);
    bus.we <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    bus.addr <= a;
    bus.re <= 1'b1;
    @(posedge clock);
    bus.re <= 1'b0;
    @(negedge clock);
    chk("rdata", {8'h00, rdata}, {8'h00, exp});
    @(posedge clock);
  endtask
  // program timer 0, settle past one wrap, then count highs and rises on both pins
  task automatic cfg(input logic [7:0] tm, cb, tp, th, rl, rh, input logic gt,
                     input logic [15:0] h0, r0, h1, r1);
    logic [15:0] hi [2];
    logic [15:0] ri [2];
    logic [1:0]  prev;
    gate_in <= {1'b1, gt};
    wr(`TPWM_A_MODE, tm);
    wr(`TPWM_A_CTRLB, cb);
    wr(`TPWM_A_TPS, tp);
    wr(`TPWM_A_TL0, th);
    wr(`TPWM_A_TH0, th);
    wr(`TPWM_A_RL0, rl);
    wr(`TPWM_A_RH0, rh);
    wr(`TPWM_A_CTRL, 8'h50);
    repeat (1100) @(posedge clock);
    hi = '{default: 16'h0};
    ri = '{default: 16'h0};
    @(negedge clock);
    prev = pin_in;
    for (int n = 0; n < 1024; n++) begin
      @(negedge clock);
      for (int g = 0; g < 2; g++) begin
        hi[g] = hi[g] + {15'h0, pin_in[g]};
        ri[g] = ri[g] + {15'h0, pin_in[g] & !prev[g]};
      end
      prev = pin_in;
    end
    @(posedge clock);
    chk("pin0 highs", hi[0], h0);
    chk("pin0 rises", ri[0], r0);
    chk("pin1 highs", hi[1], h1);
    chk("pin1 rises", ri[1], r1);
  endtask
  // timer 1 auto-reload every 16 clocks, count its baud pulses
  task automatic baud(input logic [7:0] tm, input logic [15:0] exp);
    logic [15:0] n;
    wr(`TPWM_A_MODE, tm);
    wr(`TPWM_A_TL1, 8'hF0);
    wr(`TPWM_A_TH1, 8'hF0);
    repeat (40) @(posedge clock);
    n = 16'h0;
    repeat (256) begin
      @(negedge clock);
      n = n + {15'h0, baud_tick};
    end
    @(posedge clock);
    chk("baud ticks", n, exp);
  endtask
  // main sequence; mode values keep counter select clear as pwm needs
  initial begin
    nrst = 1'b0;
    bus = '0;
    gate_in = 2'b11;
    mismatches = 0;
    checked = 0;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    rd(`TPWM_A_CTRLB, `TPWM_CTRLB_RST);
    rd(8'h97, 8'h00);
    wr(`TPWM_A_CTRLB, 8'hA5);
    rd(`TPWM_A_CTRLB, 8'hA5);
    cfg(8'h00, 8'h40, 0, 0, 0, 8'h40, 1, 256, 2, 1024, 0);
    chk("flag0", overflow_flag[0], 1);
    cfg(8'h00, 8'h41, 0, 0, 0, 8'h20, 1, 128, 1, 1024, 0);
    cfg(8'h01, 8'h40, 0, 0, 8'hFE, 8'h40, 1, 256, 2, 1024, 0);
    cfg(8'h00, 8'h40, 0, 0, 0, 8'h00, 1, 0, 0, 1024, 0);
    cfg(8'h08, 8'h40, 0, 8'h01, 0, 8'h80, 0, 0, 0, 1024, 0);
    cfg(8'h08, 8'h40, 0, 8'h01, 0, 8'h80, 1, 512, 2, 1024, 0);
    cfg(8'h02, 8'h40, 0, 8'hFC, 0, 0, 1, 512, 128, 1024, 0);
    wr(`TPWM_A_RL0, 8'h5A);
    rd(`TPWM_A_RL0, 8'h5A);
    cfg(8'h03, 8'hC0, 0, 0, 8'h40, 8'h80, 1, 256, 4, 512, 4);
    chk("flag1", overflow_flag[1], 1);
    cfg(8'h03, 8'hC0, 1, 0, 8'h40, 8'h80, 1, 256, 2, 512, 2);
    wr(`TPWM_A_TPS, 8'h00);
    baud(8'h20, 16);
    baud(8'h30, 0);
    baud(8'h23, 16);
    baud(8'h33, 0);
    tally_and_finish;
  end
  // cut a hang short well past the expected run of about 20500 cycles
  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    tally_and_finish;
  end
endmodule

// File: tb/tpwm_load.sv
// load model on the two timer pins
// assumes a pull-up on each pin, so a released pin reads high
module tpwm_load (
  // pins from the block
  input  wire tpwm_pkg::tpwm_pin_t [1:0] pin,
  // levels seen on the pins
  output logic [1:0]                     pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import tpwm_pkg::*;
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      pin_in[g] = pin[g].oe_n ? 1'b1 : pin[g].out;
    end
  end
endmodule

// File: tb/tpwm_timers_props.sv
// assertions on the ports of the timer pwm block
// assumes enables and modes change only through register writes
`include "tpwm_defs.svh"
module tpwm_timers_props (
  // clock and reset
  input wire logic                      clock,
  input wire logic                      nrst,
  // register port
  input wire tpwm_pkg::tpwm_bus_t       bus,
  input wire logic [7:0]                rdata,
  // pins, gates, flags
  input wire tpwm_pkg::tpwm_pin_t [1:0] pin,
  input wire logic [1:0]                gate_in,
  input wire logic [1:0]                overflow_flag,
  input wire logic                      baud_tick
);
  timeunit 1ns;
  timeprecision 1ns;
  import tpwm_pkg::*;
  logic [7:0] cb_q;
  logic [7:0] md_q;
  logic       t1_held;
  logic       gated;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // software view of enables and modes, so pins can be tied to their cause
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      cb_q <= `TPWM_CTRLB_RST;
      md_q <= 8'h00;
    end else if (bus.we) begin
      if (bus.addr == `TPWM_A_CTRLB) cb_q <= bus.wdata;
      if (bus.addr == `TPWM_A_MODE) md_q <= bus.wdata;
    end
  end
  // conditions that must freeze a channel
  assign t1_held = md_q[5:4] == 2'h3;
  assign gated = md_q[3] && !gate_in[0];
  a_pin0_drive:
    assert property ($past(cb_q[6]) == cb_q[6] && $past(cb_q[6], 2) == cb_q[6]
      |-> pin[0].oe_n == !cb_q[6]) else $error("pin 0 drive differs from enable");
  a_pin1_drive:
    assert property ($past(cb_q[7]) == cb_q[7] && $past(cb_q[7], 2) == cb_q[7]
      |-> pin[1].oe_n == !cb_q[7]) else $error("pin 1 drive differs from enable");
  a_ctrlb_read:
    assert property ($past(bus.re) && $past(bus.addr) == `TPWM_A_CTRLB
      |-> rdata == $past(cb_q)) else $error("control b readback wrong");
  a_rdata_idle:
    assert property (!$past(bus.re) |-> rdata == 8'h00) else $error("read data not idle");
  a_flag0_clear:
    assert property ($fell(overflow_flag[0]) |-> $past(bus.we)
      && $past(bus.addr) == `TPWM_A_CTRL && !$past(bus.wdata[5]))
      else $error("flag 0 fell without a clear");
  a_flag1_clear:
    assert property ($fell(overflow_flag[1]) |-> $past(bus.we)
      && $past(bus.addr) == `TPWM_A_CTRL && !$past(bus.wdata[7]))
      else $error("flag 1 fell without a clear");
  a_t1_frozen:
    assert property (t1_held && $past(t1_held) && $past(t1_held, 2) |-> !baud_tick)
      else $error("timer 1 ticks while held");
  a_gate_halts:
    assert property (gated && $past(gated) && $past(gated, 2) |-> $stable(pin[0].out))
      else $error("pin 0 moves while gated");
endmodule
bind tpwm_timers tpwm_timers_props i_tpwm_timers_props (
  .clock(clock), .nrst(nrst), .bus(bus), .rdata(rdata), .pin(pin), .gate_in(gate_in),
  .overflow_flag(overflow_flag), .baud_tick(baud_tick));
